// ---- include/pmam_pkg.sv ----
// Command codes, field layouts and reset values for the alert-mask and format registers
package pmam_pkg;

  // Command codes
  localparam logic [7:0] CMD_ALERT_MASK  = 8'h1B;  // Shared alert-mask command
  localparam logic [7:0] CMD_VOUT_FORMAT = 8'h20;  // Output-voltage format byte

  // Embedded status selector bytes for the alert-mask command
  localparam logic [7:0] SEL_COMM_FAULT  = 8'h7E;  // Communication/memory/logic mask
  localparam logic [7:0] SEL_OTHER       = 8'h7F;  // Other-status mask
  localparam logic [7:0] SEL_VENDOR      = 8'h80;  // Manufacturer-status mask

  // Writable bit sets; all other bits read as zero
  localparam logic [7:0] COMM_WR_BITS    = 8'hF2;  // Bits 7,6,5,4,1
  localparam logic [7:0] VENDOR_WR_BITS  = 8'hCE;  // Bits 7,6,3,2,1
  localparam logic [7:0] OTHER_FIXED     = 8'h01;  // Bit 0 hard-wired to masked
  localparam logic [7:0] FMT_WR_BITS     = 8'h9F;  // Bit 7 and bits 4:0

  // Mask bit positions
  localparam int BAD_COMMAND_ALERT_MASK   = 7;
  localparam int BAD_DATA_ALERT_MASK      = 6;
  localparam int PACKET_CHECK_ALERT_MASK  = 5;
  localparam int MEMORY_FAULT_ALERT_MASK  = 4;
  localparam int LOGIC_FAULT_ALERT_MASK   = 3;
  localparam int LINK_FAULT_ALERT_MASK    = 1;
  localparam int EARLIEST_ALERTER_MASK    = 0;
  localparam int POWERUP_EVENT_ALERT_MASK = 7;
  localparam int SELF_EVENT_ALERT_MASK    = 6;
  localparam int RESET_PIN_ALERT_MASK     = 3;
  localparam int BACKCHANNEL_ALERT_MASK   = 2;
  localparam int SYNC_FAULT_ALERT_MASK    = 1;

  // Format byte fields
  localparam int FMT_REL_BIT     = 7;              // Relative format select
  localparam int FMT_MODE_HI     = 6;
  localparam int FMT_MODE_LO     = 5;
  localparam int FMT_PARAM_HI    = 4;
  localparam int FMT_PARAM_LO    = 0;
  localparam logic [1:0] FMT_MODE_LINEAR = 2'h0;  // Only linear is supported

  // Supported exponent range, two's complement
  localparam logic signed [4:0] EXP_MOST_NEG = 5'sh14;  // -12
  localparam logic signed [4:0] EXP_LEAST_NEG = 5'sh1C; // -4

  // Values held between reset release and the nonvolatile restore
  localparam logic [7:0] COMM_RST   = 8'hF2;  // Everything masked
  localparam logic [7:0] VENDOR_RST = 8'hCE;  // Everything masked
  localparam logic [7:0] FMT_RST    = 8'h14;  // Absolute, exponent -12

endpackage

// ---- include/pmam_alert_if.sv ----
// Masks and status conditions passed from the register bank to the alert gate
`timescale 1ns/1ps
interface pmam_alert_if;
  logic [7:0] comm_mask;     // Communication/memory/logic mask
  logic [7:0] other_mask;    // Other-status mask
  logic [7:0] vendor_mask;   // Manufacturer-status mask
  logic [7:0] comm_status;   // Live communication status conditions
  logic [7:0] other_status;  // Live other-status conditions
  logic [7:0] vendor_status; // Live manufacturer status conditions
  logic       alert;         // Registered alert request

  modport regs (output comm_mask, other_mask, vendor_mask,
                output comm_status, other_status, vendor_status,
                input  alert);
  modport gate (input  comm_mask, other_mask, vendor_mask,
                input  comm_status, other_status, vendor_status,
                output alert);
endinterface

// ---- rtl/pmam_alert_gate.sv ----
// Per-bit alert gating of status conditions by their mask bits
`timescale 1ns/1ps
module pmam_alert_gate (
  // Clock and reset
  input  wire logic clock,
  input  wire logic reset_n,
  // Masks, status and alert
  pmam_alert_if.gate  alrt
);

  logic [7:0] comm_hit;    // Unmasked communication conditions
  logic [7:0] other_hit;   // Unmasked other conditions
  logic [7:0] vendor_hit;  // Unmasked manufacturer conditions
  logic       alert_r;     // Registered alert

  // One gate per bit; a set mask bit only blocks the alert, status stays
  for (genvar i = 0; i < 8; i++) begin : g_bit
    assign comm_hit[i]   = alrt.comm_status[i]   & ~alrt.comm_mask[i];
    assign other_hit[i]  = alrt.other_status[i]  & ~alrt.other_mask[i];
    assign vendor_hit[i] = alrt.vendor_status[i] & ~alrt.vendor_mask[i];
  end

  // Registered so the alert pin never glitches on mask writes
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      alert_r <= 1'b0;
    end else begin
      alert_r <= |{comm_hit, other_hit, vendor_hit};
    end
  end

  assign alrt.alert = alert_r;

endmodule

// ---- rtl/pmam_regs.sv ----
// Alert-mask and output-voltage format command registers
`timescale 1ns/1ps
module pmam_regs (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       reset_n,
  // Decoded host transaction
  input  wire logic       cmd_valid,
  input  wire logic       cmd_write,
  input  wire logic       cmd_word,
  input  wire logic [7:0] cmd_code,
  input  wire logic [7:0] cmd_sel,
  input  wire logic [7:0] cmd_wdata,
  // Transaction answer
  output logic            rsp_valid,
  output logic            rsp_ack,
  output logic [7:0]      rsp_rdata,
  // Nonvolatile restore
  input  wire logic       nvm_load,
  input  wire logic [7:0] nvm_comm_mask,
  input  wire logic [7:0] nvm_vendor_mask,
  input  wire logic [7:0] nvm_vout_format,
  // Converter state
  input  wire logic       conversion_en,
  // Status conditions
  input  wire logic [7:0] comm_status,
  input  wire logic [7:0] other_status,
  input  wire logic [7:0] vendor_status,
  // Alert request
  output logic            alert_req,
  // Format towards the conversion engine
  output logic [7:0]      vout_format,
  output logic [7:0]      vout_format_prev,
  output logic            fmt_update
);

  // Register state
  logic [7:0] comm_fault_alert_mask_r;   // Writable comm mask bits
  logic [7:0] vendor_status_alert_mask_r; // Writable vendor mask bits
  logic [7:0] output_voltage_format_r;   // Format byte, mode bits kept zero
  logic [7:0] fmt_prev_r;                // Format before the last change
  logic       fmt_update_r;              // One-cycle change pulse
  logic       rsp_valid_r;               // Answer strobe
  logic       rsp_ack_r;                 // Answer accepted flag
  logic [7:0] rsp_rdata_r;               // Answer data

  // Decode results
  logic       comm_wr;                   // Write to comm mask
  logic       vendor_wr;                 // Write to vendor mask
  logic       fmt_wr;                    // Accepted format write
  logic       accept;                    // Transaction accepted
  logic [7:0] rdata_nxt;                 // Read data for the answer
  logic [7:0] fmt_nxt;                   // Candidate format value
  logic       exp_ok;                    // Exponent within range
  logic [7:0] other_mask_val;            // Other mask, constant

  pmam_alert_if alrt ();                 // Link to the alert gate

  // Other mask has no storage at all
  assign other_mask_val = pmam_pkg::OTHER_FIXED;

  // Candidate format keeps mode zero regardless of written bits
  assign fmt_nxt = cmd_wdata & pmam_pkg::FMT_WR_BITS;

  // Exponent range check in signed arithmetic
  assign exp_ok =
    ($signed(cmd_wdata[pmam_pkg::FMT_PARAM_HI:pmam_pkg::FMT_PARAM_LO]) >=
     pmam_pkg::EXP_MOST_NEG) &&
    ($signed(cmd_wdata[pmam_pkg::FMT_PARAM_HI:pmam_pkg::FMT_PARAM_LO]) <=
     pmam_pkg::EXP_LEAST_NEG);

  // Command decode; wrong transaction shape is refused, not guessed at
  always_comb begin
    comm_wr   = 1'b0;
    vendor_wr = 1'b0;
    fmt_wr    = 1'b0;
    accept    = 1'b0;
    rdata_nxt = 8'h00;
    if (!cmd_valid) begin
      // Idle, nothing decoded
      accept = 1'b0;
    end else if (cmd_code == pmam_pkg::CMD_ALERT_MASK && cmd_word) begin
      if (cmd_sel == pmam_pkg::SEL_COMM_FAULT) begin
        // Bits 3, 2 and 0 stay zero
        comm_wr   = cmd_write;
        accept    = 1'b1;
        rdata_nxt = comm_fault_alert_mask_r & pmam_pkg::COMM_WR_BITS;
      end else if (cmd_sel == pmam_pkg::SEL_OTHER) begin
        // Read-only; writes are refused
        accept    = !cmd_write;
        rdata_nxt = other_mask_val;
      end else if (cmd_sel == pmam_pkg::SEL_VENDOR) begin
        comm_wr   = 1'b0;
        vendor_wr = cmd_write;
        accept    = 1'b1;
        rdata_nxt = vendor_status_alert_mask_r & pmam_pkg::VENDOR_WR_BITS;
      end else begin
        // Selector outside this bank
        accept = 1'b0;
      end
    end else if (cmd_code == pmam_pkg::CMD_VOUT_FORMAT && !cmd_word) begin
      if (cmd_write) begin
        // Frozen while converting; bad exponent is invalid data
        fmt_wr = !conversion_en && exp_ok;
        accept = fmt_wr;
      end else begin
        accept    = 1'b1;
        rdata_nxt = output_voltage_format_r;
      end
    end else begin
      // Unknown command or wrong transaction size
      accept = 1'b0;
    end
  end

  // Comm mask storage, restore has priority over a host write
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      comm_fault_alert_mask_r <= pmam_pkg::COMM_RST;
    end else if (nvm_load) begin
      comm_fault_alert_mask_r <= nvm_comm_mask & pmam_pkg::COMM_WR_BITS;
    end else if (comm_wr) begin
      comm_fault_alert_mask_r <= cmd_wdata & pmam_pkg::COMM_WR_BITS;
    end
  end

  // Vendor mask storage
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      vendor_status_alert_mask_r <= pmam_pkg::VENDOR_RST;
    end else if (nvm_load) begin
      vendor_status_alert_mask_r <= nvm_vendor_mask & pmam_pkg::VENDOR_WR_BITS;
    end else if (vendor_wr) begin
      vendor_status_alert_mask_r <= cmd_wdata & pmam_pkg::VENDOR_WR_BITS;
    end
  end

  // Format storage and change pulse for the conversion engine
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      output_voltage_format_r <= pmam_pkg::FMT_RST;
      fmt_prev_r              <= pmam_pkg::FMT_RST;
      fmt_update_r            <= 1'b0;
    end else if (nvm_load) begin
      // Restore is a fresh baseline, nothing to convert
      output_voltage_format_r <= nvm_vout_format & pmam_pkg::FMT_WR_BITS;
      fmt_prev_r              <= nvm_vout_format & pmam_pkg::FMT_WR_BITS;
      fmt_update_r            <= 1'b0;
    end else if (fmt_wr && fmt_nxt != output_voltage_format_r) begin
      // Old value is kept so stored commands can be rescaled
      output_voltage_format_r <= fmt_nxt;
      fmt_prev_r              <= output_voltage_format_r;
      fmt_update_r            <= 1'b1;
    end else begin
      fmt_update_r <= 1'b0;
    end
  end

  // Answer one cycle after each transaction
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rsp_valid_r <= 1'b0;
      rsp_ack_r   <= 1'b0;
      rsp_rdata_r <= 8'h00;
    end else begin
      rsp_valid_r <= cmd_valid;
      rsp_ack_r   <= accept;
      // Writes and refusals answer with zero data
      rsp_rdata_r <= (cmd_valid && !cmd_write && accept) ? rdata_nxt : 8'h00;
    end
  end

  // Masks and status towards the gate; sync and self-event bits are
  // left to software, which must keep them set where the alert is unwanted
  assign alrt.comm_mask     = comm_fault_alert_mask_r & pmam_pkg::COMM_WR_BITS;
  assign alrt.other_mask    = other_mask_val;
  assign alrt.vendor_mask   = vendor_status_alert_mask_r & pmam_pkg::VENDOR_WR_BITS;
  assign alrt.comm_status   = comm_status;
  assign alrt.other_status  = other_status;
  assign alrt.vendor_status = vendor_status;

  // Alert gating per bit
  pmam_alert_gate u_gate (
    .clock   (clock),
    .reset_n (reset_n),
    .alrt    (alrt.gate)
  );

  // Outputs
  assign alert_req        = alrt.alert;
  assign vout_format      = output_voltage_format_r;
  assign vout_format_prev = fmt_prev_r;
  assign fmt_update       = fmt_update_r;
  assign rsp_valid        = rsp_valid_r;
  assign rsp_ack          = rsp_ack_r;
  assign rsp_rdata        = rsp_rdata_r;

endmodule

// ---- verification/pmam_regs_sva.sv ----
// Port-level assertions for the alert-mask and format registers
`timescale 1ns/1ps
module pmam_regs_sva (
  // Clock, reset and inputs
  input logic       clock,
  input logic       reset_n,
  input logic       cmd_valid,
  input logic       cmd_write,
  input logic       cmd_word,
  input logic [7:0] cmd_code,
  input logic [7:0] cmd_sel,
  input logic       nvm_load,
  input logic       conversion_en,
  input logic [7:0] comm_status,
  input logic [7:0] other_status,
  input logic [7:0] vendor_status,
  // Design outputs
  input logic       rsp_valid,
  input logic       rsp_ack,
  input logic [7:0] rsp_rdata,
  input logic       alert_req,
  input logic [7:0] vout_format,
  input logic [7:0] vout_format_prev,
  input logic       fmt_update
);
  // Single domain, so one clock and one reset for all
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  // Exactly one answer per request, one cycle later
  property p_rsp; rsp_valid == $past(cmd_valid); endproperty
  a_rsp: assert property (p_rsp) else $error("answer timing wrong");
  // Wrong transaction forms are refused
  property p_byte; cmd_valid && cmd_code == 8'h1B && !cmd_word |=> !rsp_ack; endproperty
  a_byte: assert property (p_byte) else $error("byte form of mask accepted");
  property p_word; cmd_valid && cmd_code == 8'h20 && cmd_word |=> !rsp_ack; endproperty
  a_word: assert property (p_word) else $error("word form of format accepted");
  // Other mask always answers the fixed value
  property p_oth;
    cmd_valid && !cmd_write && cmd_word && cmd_code == 8'h1B && cmd_sel == 8'h7F
      |=> rsp_ack && rsp_rdata == 8'h01;
  endproperty
  a_oth: assert property (p_oth) else $error("other mask read wrong");
  // Unimplemented comm bits never read back set
  property p_czero;
    cmd_valid && !cmd_write && cmd_code == 8'h1B && cmd_sel == 8'h7E |=> (rsp_rdata & 8'h0D) == 8'h00;
  endproperty
  a_czero: assert property (p_czero) else $error("comm reserved bit set");
  // Mode stays linear and the exponent in range
  property p_mode; vout_format[6:5] == 2'h0 && vout_format[4:0] inside {[5'h14:5'h1C]}; endproperty
  a_mode: assert property (p_mode) else $error("format field illegal");
  // Frozen while converting, except for a restore
  property p_frz; conversion_en && !nvm_load |=> $stable(vout_format); endproperty
  a_frz: assert property (p_frz) else $error("format moved while converting");
  // Change pulse only after an accepted host write that changed the value
  property p_upd;
    fmt_update |-> vout_format != vout_format_prev
      && $past(cmd_valid && cmd_write && cmd_code == 8'h20 && !conversion_en);
  endproperty
  a_upd: assert property (p_upd) else $error("spurious format update");
  // No active maskable condition, no alert; earliest-alerter bit never alerts
  property p_quiet;
    comm_status == 8'h00 && vendor_status == 8'h00 && other_status[7:1] == 7'h00 |=> !alert_req;
  endproperty
  a_quiet: assert property (p_quiet) else $error("alert without cause");
endmodule
bind pmam_regs pmam_regs_sva u_sva (.*);

// ---- verification/pmam_host.sv ----
// Host model: launches one request per cycle just after an edge
`timescale 1ns/1ps
module pmam_host (
  // Clock
  input  logic       clock,
  // Request lines
  output logic       cmd_valid = 1'b0,
  output logic       cmd_write = 1'b0,
  output logic       cmd_word  = 1'b0,
  output logic [7:0] cmd_code  = 8'h00,
  output logic [7:0] cmd_sel   = 8'h00,
  output logic [7:0] cmd_wdata = 8'h00
);
  // Request held across the next edge; consecutive calls run back to back
  task send(input logic w, wd, input logic [7:0] c, s, d);
    @(posedge clock);
    #1 cmd_valid = 1'b1;
    cmd_write = w;
    cmd_word = wd;
    cmd_code = c;
    cmd_sel = s;
    cmd_wdata = d;
  endtask
  // Idle: selector and data stop showing their last value
  task rest;
    @(posedge clock);
    #1 cmd_valid = 1'b0;
    cmd_sel = ~cmd_sel;
    cmd_wdata = ~cmd_wdata;
  endtask
endmodule

// ---- verification/pmam_regs_tb_top.sv ----
// Self-checking bench for the alert-mask and format registers
`timescale 1ns/1ps
module pmam_regs_tb_top;
  // Bench inputs, reference registers and bookkeeping
  logic        clock = 1'b0, reset_n = 1'b0, nvm_load = 1'b0, conversion_en = 1'b0;
  logic [7:0]  nvm_comm_mask = 8'h00, nvm_vendor_mask = 8'h00, nvm_vout_format = 8'h00;
  logic [7:0]  comm_status = 8'h00, other_status = 8'h00, vendor_status = 8'h00;
  logic [7:0]  comm = 8'hF2, vend = 8'hCE, fmt = 8'h14, pv = 8'h14, r;
  logic [7:0]  sl[4] = '{8'h7E, 8'h7F, 8'h80, 8'h00};
  logic [7:0]  fv[7] = '{8'h14, 8'h13, 8'hFC, 8'h1D, 8'h94, 8'h94, 8'h0C};
  logic [15:0] lf = 16'hB01D;
  logic [17:0] exp_q[$];
  int          n_fail = 0, check_count = 0, cyc = 0;
  // Host lines and design outputs
  logic        cmd_valid, cmd_write, cmd_word, rsp_valid, rsp_ack, alert_req, fmt_update;
  logic [7:0]  cmd_code, cmd_sel, cmd_wdata, rsp_rdata, vout_format, vout_format_prev;
  pmam_host host (.*);
  pmam_regs dut (.*);
  // Free-running 40 MHz clock
  initial begin
    forever #12.5 clock = ~clock;
  end
  // Shift-register source of data and status patterns
  function automatic logic [7:0] rnd();
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf[7:0];
  endfunction
  // Compare and count; an unknown matches only an unknown in the same bit
  task check(input string nm, input logic [17:0] seen, want);
    check_count++;
    if (seen !== want) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, want, seen);
    end
  endtask
  // Counts, verdict, end of run
  task wrap_up;
    check("unanswered", {17'h00000, exp_q.size() != 0}, 18'h00000);
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Note the expected answer from the reference copies, then issue the request
  task op(input logic w, wd, input logic [7:0] c, s, d);
    logic       ok;
    logic       u;
    logic [7:0] q;
    ok = c == 8'h1B ? wd && s inside {8'h7E, 8'h7F, 8'h80} && !(w && s == 8'h7F)
       : c == 8'h20 && !wd && !(w && (conversion_en || d[4:0] < 5'h14 || d[4:0] > 5'h1C));
    q = c == 8'h20 ? fmt : s == 8'h7E ? comm : s == 8'h7F ? 8'h01 : vend;
    if (!ok || w) q = 8'h00;
    u = ok && w && c == 8'h20 && (d & 8'h9F) != fmt;
    if (u) pv = fmt;
    if (ok && w && c == 8'h20) fmt = d & 8'h9F;
    if (ok && w && c == 8'h1B && s == 8'h7E) comm = d & 8'hF2;
    if (ok && w && c == 8'h1B && s == 8'h80) vend = d & 8'hCE;
    exp_q.push_back({pv, u, ok, q});
    host.send(w, wd, c, s, d);
  endtask
  // Back-to-back reads of every register
  task rd_all;
    for (int i = 0; i < 4; i++) op(1'b0, i < 3, i < 3 ? 8'h1B : 8'h20, sl[i], 8'h00);
  endtask
  // Answers matched against the oldest note; cycle ceiling cuts a hang short
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (rsp_valid === 1'b1)
      check("answer", {vout_format_prev, fmt_update, rsp_ack, rsp_rdata}, exp_q.pop_front());
    if (cyc == 4000) begin
      n_fail++;
      wrap_up();
    end
  end
  // Main sequence
  initial begin
    repeat (20) @(posedge clock);
    #1 reset_n = 1'b1;
    check("format", {10'h000, vout_format}, {10'h000, fmt});
    rd_all();
    host.rest();
    // Restore from nonvolatile values; sync mask kept set
    nvm_comm_mask = rnd();
    nvm_vendor_mask = rnd() | 8'h02;
    nvm_vout_format = 8'hF8;
    nvm_load = 1'b1;
    comm = nvm_comm_mask & 8'hF2;
    vend = nvm_vendor_mask & 8'hCE;
    fmt = 8'h98;
    pv = 8'h98;
    @(posedge clock);
    #1 nvm_load = 1'b0;
    check("format", {10'h000, vout_format}, {10'h000, fmt});
    // Random masks, then random live conditions against them
    for (int i = 0; i < 6; i++) begin
      op(1'b1, 1'b1, 8'h1B, 8'h7E, rnd());
      op(1'b1, 1'b1, 8'h1B, 8'h80, rnd() | 8'h02);
      op(1'b1, 1'b1, 8'h1B, 8'h7F, rnd());
      rd_all();
      host.rest();
      r = i == 0 ? 8'h00 : rnd();
      comm_status = r & 8'hF2;
      vendor_status = {r[2:0], r[7:3]} & 8'hCE;
      other_status = {7'h00, r[4]};
      repeat (2) @(posedge clock);
      #1 r = {7'h00, |(comm_status & ~comm) | |(vendor_status & ~vend)};
      check("alert", {17'h00000, alert_req}, {10'h000, r});
    end
    // Wrong forms, unknown selector and code, format boundaries
    op(1'b0, 1'b0, 8'h1B, 8'h7E, 8'h00);
    op(1'b0, 1'b1, 8'h20, 8'h00, 8'h00);
    op(1'b0, 1'b1, 8'h1B, 8'h7D, 8'h00);
    op(1'b1, 1'b1, 8'h21, 8'h7E, 8'h00);
    foreach (fv[i]) op(1'b1, 1'b0, 8'h20, 8'h00, fv[i]);
    host.rest();
    conversion_en = 1'b1;
    op(1'b1, 1'b0, 8'h20, 8'h00, 8'h18);
    rd_all();
    host.rest();
    conversion_en = 1'b0;
    // Second reset in mid-run brings back the held values
    @(posedge clock);
    #1 reset_n = 1'b0;
    comm = 8'hF2;
    vend = 8'hCE;
    fmt = 8'h14;
    pv = 8'h14;
    repeat (2) @(posedge clock);
    #1 reset_n = 1'b1;
    rd_all();
    host.rest();
    repeat (2) @(posedge clock);
    wrap_up();
  end
endmodule
